// ### src/tpwm_regs.svh
`ifndef TPWM_REGS_SVH
`define TPWM_REGS_SVH

// register byte offsets
`define TPWM_OFS_MODE    12'h100
`define TPWM_OFS_CTRL1   12'h104
`define TPWM_OFS_COUNT   12'h108
`define TPWM_OFS_STATUS  12'h10C
`define TPWM_OFS_GRA     12'h110
`define TPWM_OFS_GRB     12'h114
`define TPWM_OFS_GRC     12'h118
`define TPWM_OFS_GRD     12'h11C
`define TPWM_OFS_CTRL2   12'h130

// pwm_control_two fields
`define TPWM_C2_POL_B    0
`define TPWM_C2_POL_D    2
`define TPWM_C2_HALT     5
`define TPWM_C2_EDGE_LO  6
`define TPWM_C2_EDGE_HI  7
`define TPWM_C2_RST      8'h18
`define TPWM_C2_UNUSED   2'h3

// timer_mode_reg fields
`define TPWM_MD_START    0
`define TPWM_MD_MODE_LO  1
`define TPWM_MD_MODE_HI  2
`define TPWM_MD_BUF_C    3
`define TPWM_MD_BUF_D    4

// timer_control_one fields
`define TPWM_C1_CSRC_LO  0
`define TPWM_C1_CSRC_HI  2
`define TPWM_C1_COUNTER_CLEAR_SEL     3
`define TPWM_C1_INIT_LO  4
`define TPWM_C1_INIT_HI  6

// reset values
`define TPWM_GR_RST      16'hFFFF

// prescaler masks
`define TPWM_DIV_F2      5'h01
`define TPWM_DIV_F4      5'h03
`define TPWM_DIV_F8      5'h07
`define TPWM_DIV_F32     5'h1F

// bus responses
`define TPWM_RESP_OKAY   2'h0
`define TPWM_RESP_SLVERR 2'h2

`endif

// ### src/tpwm_pkg.sv
package tpwm_pkg;

    typedef logic [11:0] tpwm_addr_t;
    typedef logic [31:0] tpwm_data_t;
    typedef logic [15:0] tpwm_word_t;

    // timer operating modes as held in timer_mode_reg
    typedef enum logic [1:0] {
        TPWM_MODE_TIMER,
        TPWM_MODE_COMPARE,
        TPWM_MODE_PWM,
        TPWM_MODE_PWM2
    } tpwm_mode_e;

    typedef enum logic [1:0] {
        TPWM_IDLE,
        TPWM_ARMED,
        TPWM_RUN
    } tpwm_state_e;

    typedef struct packed {
        logic [4:0] presc;
        logic       ext_q;
        logic       osc_q;
        logic       oscd_q;
    } tpwm_src_s;

    typedef struct packed {
        logic active;
        logic pin;
    } tpwm_chan_s;

    typedef struct packed {
        logic        aw_held;
        tpwm_addr_t  awaddr_q;
        logic        w_held;
        tpwm_data_t  wdata_q;
        logic [3:0]  wstrb_q;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        tpwm_data_t  rdata;
        logic [1:0]  rresp;
        logic        start;
        tpwm_mode_e  mode;
        logic        buf_c;
        logic        buf_d;
        logic [2:0]  csrc;
        logic        counter_clear_sel;
        logic [2:0]  init_lvl;
        logic [2:0]  pol;
        logic        halt;
        logic [1:0]  edge_sel;
        tpwm_word_t  cnt;
        tpwm_word_t  gra;
        tpwm_word_t  grb;
        tpwm_word_t  grc;
        tpwm_word_t  grd;
        tpwm_state_e state;
        logic        trig_q;
    } tpwm_top_s;

endpackage : tpwm_pkg

// ### src/tpwm_count_source.sv
`timescale 1ns/10ps
`default_nettype none
`include "tpwm_regs.svh"

module tpwm_count_source (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [2:0] sel,
    input  wire logic       external_clock_pin,
    input  wire logic       fast_osc_clock,
    input  wire logic       fast_osc_divided_clock,
    output logic            tick
);
    import tpwm_pkg::*;

    tpwm_src_s st;
    tpwm_src_s next_st;

    // prescaler and input history
    always_comb begin
        next_st        = st;
        next_st.presc  = st.presc + 5'h01;
        next_st.ext_q  = external_clock_pin;
        next_st.osc_q  = fast_osc_clock;
        next_st.oscd_q = fast_osc_divided_clock;
    end

    // count event select
    always_comb begin
        case (sel)
            3'h0:    tick = 1'b1;
            3'h1:    tick = (st.presc & `TPWM_DIV_F2) == 5'h00;
            3'h2:    tick = (st.presc & `TPWM_DIV_F4) == 5'h00;
            3'h3:    tick = (st.presc & `TPWM_DIV_F8) == 5'h00;
            3'h4:    tick = (st.presc & `TPWM_DIV_F32) == 5'h00;
            3'h5:    tick = external_clock_pin & ~st.ext_q;
            3'h6:    tick = fast_osc_clock & ~st.osc_q;
            default: tick = fast_osc_divided_clock & ~st.oscd_q;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : tpwm_count_source
`default_nettype wire

// ### src/tpwm_channel.sv
`timescale 1ns/10ps
`default_nettype none

module tpwm_channel (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic load_init,
    input  wire logic init_active,
    input  wire logic set_active,
    input  wire logic clr_active,
    input  wire logic apply_pol,
    input  wire logic pol_high,
    output logic      pin
);
    import tpwm_pkg::*;

    tpwm_chan_s st;
    tpwm_chan_s next_st;

    // level tracking
    always_comb begin
        next_st = st;
        if (load_init) begin
            next_st.active = init_active;
        end else if (set_active && clr_active) begin
            next_st.active = st.active;
        end else if (set_active) begin
            next_st.active = 1'b1;
        end else if (clr_active) begin
            next_st.active = 1'b0;
        end
        // polarity only matters in pwm mode
        if (apply_pol) begin
            next_st.pin = next_st.active ~^ pol_high;
        end else begin
            next_st.pin = next_st.active;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pin = st.pin;

endmodule : tpwm_channel
`default_nettype wire

// ### src/tpwm_timer_top.sv
// Summary of operation
// - control bits zero to two set pin polarity
// - bits three and four read one
// - bit five halts counter at period match
// - bits seven:six pick trigger edge
// - polarity bits act only in pwm mode
// - halt bit acts in compare, pwm, pwm2
// - trigger edge field acts only in pwm2
// - register a sets pwm period
// - registers b, c, d are change points
// - buffer bits make c, d next values
// - change point equal period keeps level
// - pwm2 gives one delayed pulse then halts
// - pwm2 uses general registers a, b, c
// - pwm2 count clock from eight sources
// - counter steps once per source event
// - pwm2 period is register a plus one
// - pulse width is b minus c
// - wait to active is c plus one
// - trigger edge starts armed pwm2 counting
// - halt restores pin b, optional clear
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "tpwm_regs.svh"

module tpwm_timer_top (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire tpwm_pkg::tpwm_addr_t awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire tpwm_pkg::tpwm_data_t wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire tpwm_pkg::tpwm_addr_t araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output tpwm_pkg::tpwm_data_t     rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    input  wire logic                external_clock_pin,
    input  wire logic                fast_osc_clock,
    input  wire logic                fast_osc_divided_clock,
    input  wire logic                external_trigger_pin,
    output logic                     output_pin_b,
    output logic                     output_pin_c,
    output logic                     output_pin_d
);
    import tpwm_pkg::*;

    tpwm_top_s   st;
    tpwm_top_s   next_st;
    logic        tick;
    logic        step;
    logic        hit_a;
    logic        hit_b;
    logic        hit_c;
    logic        hit_d;
    logic        is_pwm;
    logic        is_pwm2;
    logic        halt_ok;
    logic        trig_ok;
    logic        trig_edge;
    logic        going;
    logic        stopping;
    logic        do_write;
    logic [2:0]  set_v;
    logic [2:0]  clr_v;
    logic [2:0]  load_v;
    logic [2:0]  pin_v;
    tpwm_data_t  rd;
    tpwm_data_t  wd;
    logic [3:0]  ws;

    // mapped offsets
    function automatic logic tpwm_mapped(input tpwm_addr_t a);
        case (a)
            `TPWM_OFS_MODE, `TPWM_OFS_CTRL1, `TPWM_OFS_COUNT,
            `TPWM_OFS_STATUS, `TPWM_OFS_GRA, `TPWM_OFS_GRB,
            `TPWM_OFS_GRC, `TPWM_OFS_GRD, `TPWM_OFS_CTRL2:
                tpwm_mapped = 1'b1;
            default: tpwm_mapped = 1'b0;
        endcase
    endfunction : tpwm_mapped

    // byte-lane merge
    function automatic tpwm_word_t tpwm_merge(input tpwm_word_t old,
                                              input tpwm_data_t d,
                                              input logic [3:0] s);
        tpwm_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : tpwm_merge

    // selected trigger edge
    function automatic logic tpwm_edge(input logic [1:0] sel,
                                       input logic now,
                                       input logic was);
        case (sel)
            2'h1:    tpwm_edge = now & ~was;
            2'h2:    tpwm_edge = ~now & was;
            2'h3:    tpwm_edge = now ^ was;
            default: tpwm_edge = 1'b0;
        endcase
    endfunction : tpwm_edge

    // count event generator
    tpwm_count_source u_src (
        .aclk                   (aclk),
        .aresetn                (aresetn),
        .sel                    (st.csrc),
        .external_clock_pin     (external_clock_pin),
        .fast_osc_clock         (fast_osc_clock),
        .fast_osc_divided_clock (fast_osc_divided_clock),
        .tick                   (tick)
    );

    // mode qualifiers and matches
    always_comb begin
        is_pwm    = st.mode == TPWM_MODE_PWM;
        is_pwm2   = st.mode == TPWM_MODE_PWM2;
        halt_ok   = st.halt && (st.mode != TPWM_MODE_TIMER);
        trig_ok   = is_pwm2 && st.halt && (st.edge_sel != 2'h0);
        trig_edge = tpwm_edge(st.edge_sel, external_trigger_pin,
                              st.trig_q);
        step      = (st.state == TPWM_RUN) && tick;
        hit_a     = st.cnt == st.gra;
        hit_b     = st.cnt == st.grb;
        hit_c     = st.cnt == st.grc;
        hit_d     = st.cnt == st.grd;
        going     = (st.state == TPWM_IDLE) && st.start;
        stopping  = ((st.state == TPWM_RUN) && step && hit_a && halt_ok)
                    || ((st.state != TPWM_IDLE) && !st.start);
        do_write  = st.aw_held && st.w_held && !st.bvalid;
        wd        = st.wdata_q;
        ws        = st.wstrb_q;
    end

    // pin events per mode
    always_comb begin
        set_v  = 3'h0;
        clr_v  = 3'h0;
        load_v = {3{going}};
        if (is_pwm) begin
            set_v[0] = step && hit_b;
            clr_v[0] = step && hit_a;
            set_v[1] = step && hit_c && !st.buf_c;
            clr_v[1] = step && hit_a && !st.buf_c;
            set_v[2] = step && hit_d && !st.buf_d;
            clr_v[2] = step && hit_a && !st.buf_d;
        end else if (is_pwm2) begin
            set_v[0] = step && hit_c;
            clr_v[0] = step && hit_b;
            load_v[0] = going || stopping;
        end
    end

    // one output stage per pin
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_chan
            tpwm_channel u_chan (
                .aclk        (aclk),
                .aresetn     (aresetn),
                .load_init   (load_v[gi]),
                .init_active (st.init_lvl[gi]),
                .set_active  (set_v[gi]),
                .clr_active  (clr_v[gi]),
                .apply_pol   (is_pwm),
                .pol_high    (st.pol[gi]),
                .pin         (pin_v[gi])
            );
        end
    endgenerate

    // read data mux
    always_comb begin
        case (araddr)
            `TPWM_OFS_MODE:   rd = {27'h0, st.buf_d, st.buf_c, st.mode,
                                    st.start};
            `TPWM_OFS_CTRL1:  rd = {25'h0, st.init_lvl, st.counter_clear_sel, st.csrc};
            `TPWM_OFS_COUNT:  rd = {16'h0, st.cnt};
            `TPWM_OFS_STATUS: rd = {27'h0, pin_v,
                                    st.state == TPWM_ARMED,
                                    st.state == TPWM_RUN};
            `TPWM_OFS_GRA:    rd = {16'h0, st.gra};
            `TPWM_OFS_GRB:    rd = {16'h0, st.grb};
            `TPWM_OFS_GRC:    rd = {16'h0, st.grc};
            `TPWM_OFS_GRD:    rd = {16'h0, st.grd};
            `TPWM_OFS_CTRL2:  rd = {24'h0, st.edge_sel, st.halt,
                                    `TPWM_C2_UNUSED, st.pol};
            default:          rd = 32'h0;
        endcase
    end

    // bus slave, counter sequencing and register writes
    always_comb begin
        next_st        = st;
        next_st.trig_q = external_trigger_pin;
        // aw and w taken independently
        if (awvalid && awready) begin
            next_st.aw_held  = 1'b1;
            next_st.awaddr_q = awaddr;
        end
        if (wvalid && wready) begin
            next_st.w_held  = 1'b1;
            next_st.wdata_q = wdata;
            next_st.wstrb_q = wstrb;
        end
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = rd;
            next_st.rresp  = tpwm_mapped(araddr) ? `TPWM_RESP_OKAY
                                                 : `TPWM_RESP_SLVERR;
        end

        // counting sequence
        case (st.state)
            TPWM_IDLE: begin
                if (st.start) begin
                    next_st.state = trig_ok ? TPWM_ARMED : TPWM_RUN;
                end
            end
            TPWM_ARMED: begin
                if (!st.start) begin
                    next_st.state = TPWM_IDLE;
                end else if (trig_edge) begin
                    next_st.state = TPWM_RUN;
                end
            end
            TPWM_RUN: begin
                if (!st.start) begin
                    next_st.state = TPWM_IDLE;
                end else if (step && hit_a) begin
                    // period: reload, clear or halt
                    if (is_pwm && st.buf_c) begin
                        next_st.gra = st.grc;
                    end
                    if (is_pwm && st.buf_d) begin
                        next_st.grb = st.grd;
                    end
                    if (halt_ok) begin
                        next_st.cnt = st.counter_clear_sel ? 16'h0000 : st.cnt;
                        if (trig_ok) begin
                            next_st.state = TPWM_ARMED;
                        end else begin
                            next_st.start = 1'b0;
                            next_st.state = TPWM_IDLE;
                        end
                    end else begin
                        next_st.cnt = st.counter_clear_sel ? 16'h0000
                                              : st.cnt + 16'h0001;
                    end
                end else if (step) begin
                    next_st.cnt = st.cnt + 16'h0001;
                end
            end
            default: next_st.state = TPWM_IDLE;
        endcase

        // register write; software wins
        if (do_write) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = tpwm_mapped(st.awaddr_q) ? `TPWM_RESP_OKAY
                                                       : `TPWM_RESP_SLVERR;
            case (st.awaddr_q)
                `TPWM_OFS_MODE: begin
                    if (ws[0]) begin
                        next_st.start = wd[`TPWM_MD_START];
                        next_st.mode  = tpwm_mode_e'(
                            wd[`TPWM_MD_MODE_HI:`TPWM_MD_MODE_LO]);
                        next_st.buf_c = wd[`TPWM_MD_BUF_C];
                        next_st.buf_d = wd[`TPWM_MD_BUF_D];
                    end
                end
                `TPWM_OFS_CTRL1: begin
                    if (ws[0]) begin
                        next_st.csrc     =
                            wd[`TPWM_C1_CSRC_HI:`TPWM_C1_CSRC_LO];
                        next_st.counter_clear_sel     = wd[`TPWM_C1_COUNTER_CLEAR_SEL];
                        next_st.init_lvl =
                            wd[`TPWM_C1_INIT_HI:`TPWM_C1_INIT_LO];
                    end
                end
                `TPWM_OFS_COUNT: next_st.cnt = tpwm_merge(st.cnt, wd, ws);
                `TPWM_OFS_GRA:   next_st.gra = tpwm_merge(st.gra, wd, ws);
                `TPWM_OFS_GRB:   next_st.grb = tpwm_merge(st.grb, wd, ws);
                `TPWM_OFS_GRC:   next_st.grc = tpwm_merge(st.grc, wd, ws);
                `TPWM_OFS_GRD:   next_st.grd = tpwm_merge(st.grd, wd, ws);
                `TPWM_OFS_CTRL2: begin
                    if (ws[0]) begin
                        // bits 4:3 not stored
                        next_st.pol      =
                            wd[`TPWM_C2_POL_D:`TPWM_C2_POL_B];
                        next_st.halt     = wd[`TPWM_C2_HALT];
                        next_st.edge_sel =
                            wd[`TPWM_C2_EDGE_HI:`TPWM_C2_EDGE_LO];
                    end
                end
                default: next_st.bvalid = 1'b1; // unmapped or status: nothing stored
            endcase
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st     <= '0;
            st.gra <= `TPWM_GR_RST;
            st.grb <= `TPWM_GR_RST;
            st.grc <= `TPWM_GR_RST;
            st.grd <= `TPWM_GR_RST;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign awready      = !st.aw_held && !st.bvalid;
    assign wready       = !st.w_held && !st.bvalid;
    assign arready      = !st.rvalid;
    assign bvalid       = st.bvalid;
    assign bresp        = st.bresp;
    assign rvalid       = st.rvalid;
    assign rdata        = st.rdata;
    assign rresp        = st.rresp;
    assign output_pin_b = pin_v[0];
    assign output_pin_c = pin_v[1];
    assign output_pin_d = pin_v[2];

endmodule : tpwm_timer_top
`default_nettype wire

// ### tb/tpwm_props.sv
`timescale 1ns/10ps
`default_nettype none
module tpwm_props (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 awvalid,
    input wire logic                 awready,
    input wire logic                 wvalid,
    input wire logic                 wready,
    input wire logic                 bvalid,
    input wire tpwm_pkg::tpwm_addr_t araddr,
    input wire logic                 arvalid,
    input wire logic                 arready,
    input wire tpwm_pkg::tpwm_data_t rdata,
    input wire logic [1:0]           rresp,
    input wire logic                 rvalid,
    input wire logic                 output_pin_b
);
    import tpwm_pkg::*;
    tpwm_addr_t ra;
    // read address
    always_ff @(posedge aclk) begin
        if (arvalid && arready) ra <= araddr;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // write answer
    property p_wr_resp;
        awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("late write resp");
    property p_aw_block; bvalid |-> !awready && !wready; endproperty
    a_aw_block: assert property (p_aw_block) else $error("write not held");
    property p_rd_resp; arvalid && arready |=> rvalid; endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("late read data");
    property p_ar_block; rvalid |-> !arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read not held");
    // control two read layout
    property p_ctl2_ones;
        rvalid && ra == 12'h130 |-> rdata[4:3] == 2'h3 && rdata[31:8] == '0;
    endproperty
    a_ctl2_ones: assert property (p_ctl2_ones) else $error("ctrl2 bits");
    property p_word16;
        rvalid && ra inside {[12'h108:12'h11C]} |-> rdata[31:16] == 16'h0000;
    endproperty
    a_word16: assert property (p_word16) else $error("word too wide");
    property p_slverr; rvalid && rresp == 2'h2 |-> rdata == '0; endproperty
    a_slverr: assert property (p_slverr) else $error("error data not 0");
    property p_rst_out;
        $rose(aresetn) |-> !bvalid && !rvalid && !output_pin_b && awready;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("bad reset state");
    c_write: cover property (awvalid && awready && wvalid && wready);
    c_err: cover property (rvalid && rresp == 2'h2);
    c_pulse: cover property ($fell(output_pin_b));
endmodule : tpwm_props
bind tpwm_timer_top tpwm_props tpwm_props_inst (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .output_pin_b
);
`default_nettype wire

// ### tb/tpwm_partner.sv
`timescale 1ns/10ps
`default_nettype none
module tpwm_partner (
    input  wire logic aclk,
    input  wire logic run_clk,
    input  wire logic trig_lvl,
    input  wire logic output_pin_b,
    output logic      external_clock_pin,
    output logic      external_trigger_pin,
    output logic      fast_osc_clock,
    output logic      fast_osc_divided_clock,
    output int        hi_len,
    output int        period,
    output int        edges
);
    logic prev;
    int   ph;
    int   per_cnt;
    int   hi_cnt;
    initial begin
        {external_clock_pin, external_trigger_pin, prev} = '0;
        {fast_osc_clock, fast_osc_divided_clock} = '0;
        {ph, per_cnt, hi_cnt, hi_len, period, edges} = '0;
    end
    // sources: periods 2, 8 and 4 cycles
    always @(posedge aclk) begin
        ph <= ph + 1;
        fast_osc_clock <= ~fast_osc_clock;
        fast_osc_divided_clock <= ph[2];
        external_clock_pin <= run_clk & ph[1]; // still when not running
        external_trigger_pin <= trig_lvl;
        prev <= output_pin_b;
        per_cnt <= per_cnt + 1;
        hi_cnt <= hi_cnt + 1;
        if (output_pin_b != prev) edges <= edges + 1;
        if (output_pin_b && !prev) begin
            period <= per_cnt;
            per_cnt <= 1;
            hi_cnt <= 1;
        end
        if (!output_pin_b && prev) hi_len <= hi_cnt;
    end
endmodule : tpwm_partner
`default_nettype wire

// ### tb/test_timer_pwm_and_pwm2_output.sv
`timescale 1ns/10ps
`default_nettype none
`include "tpwm_regs.svh"
module test_timer_pwm_and_pwm2_output;
    import tpwm_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, run_clk, trig_lvl;
    logic        external_clock_pin, fast_osc_clock, fast_osc_divided_clock;
    logic        external_trigger_pin, output_pin_b, output_pin_c, output_pin_d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [15:0] lfsr;
    tpwm_addr_t  awaddr, araddr;
    tpwm_data_t  wdata, rdata, d;
    int          hi_len, period, edges, e0, m, n, p, mismatches, samples_checked;
    int          dv_tab[8] = '{1, 2, 4, 8, 32, 4, 2, 8};
    tpwm_timer_top tpwm_timer_top_inst (.*);
    tpwm_partner tpwm_partner_inst (.*);
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // write: each channel released when taken
    task automatic wr(input tpwm_addr_t a, input tpwm_data_t v);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask : wr
    task automatic rd(input tpwm_addr_t a);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready && arvalid) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask : rd
    // setup, mode with start written last
    task automatic cfg(input int ga, gb, gc, c1, c2, md);
        wr(`TPWM_OFS_GRA, ga);
        wr(`TPWM_OFS_GRB, gb);
        wr(`TPWM_OFS_GRC, gc);
        wr(`TPWM_OFS_COUNT, 32'h0);
        wr(`TPWM_OFS_CTRL1, c1);
        wr(`TPWM_OFS_CTRL2, c2);
        wr(`TPWM_OFS_MODE, md);
    endtask : cfg
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    // watchdog
    initial begin
        #400000;
        mismatches++;
        print_verdict();
    end
    initial begin
        {awvalid, wvalid, arvalid, run_clk, trig_lvl, aresetn} = '0;
        {awaddr, araddr, wdata} = '0;
        {bready, rready, wstrb} = '1;
        lfsr = 16'h007C;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`TPWM_OFS_CTRL2);
        check("ctrl2 reset", d, 32'h18);
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            wr(`TPWM_OFS_CTRL2, {24'h0, lfsr[7:0] & 8'hE7});
            rd(`TPWM_OFS_CTRL2);
            check("ctrl2", d, {24'h0, lfsr[7:0] | 8'h18});
        end
        wr(`TPWM_OFS_COUNT, 32'hABCD_1234);
        rd(`TPWM_OFS_COUNT);
        check("counter", d, 32'h1234);
        rd(12'h200);
        check("unmapped resp", r, 2'h2);
        check("unmapped data", d, 32'h0);
        wr(12'h200, 32'h0);
        check("unmapped wr resp", r, 2'h2);
        $display("test registers done");
        // pwm period and width, both levels
        for (int pol = 0; pol < 2; pol++) begin
            lfsr = lfsr_next(lfsr);
            m = 9 + lfsr[3:0];
            n = 1 + lfsr[6:4];
            cfg(m, n, 0, 32'h8, 32'hC0 | pol, 32'h5);
            repeat (3 * m + 9) @(posedge aclk);
            check("pwm period", period, m + 1);
            check("pwm high", hi_len, pol ? m - n : n + 1);
            wr(`TPWM_OFS_MODE, 32'h0);
        end
        cfg(m, m, 0, 32'h8, 32'h1, 32'h5);
        repeat (4) @(posedge aclk);
        e0 = edges;
        repeat (3 * m) @(posedge aclk);
        check("pwm equal", edges - e0, 0);
        wr(`TPWM_OFS_MODE, 32'h0);
        $display("test pwm done");
        // one pulse per count source
        run_clk <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            lfsr = lfsr_next(lfsr);
            p = 1 + lfsr[1:0];
            n = p + 1 + lfsr[3:2];
            m = n + lfsr[5:4];
            e0 = edges;
            cfg(m, n, p, s + (s & 2) * 4, s[0] ? 39 : 32, 7);
            repeat ((m + 3) * dv_tab[s] + 20) @(posedge aclk);
            check("pwm2 width", hi_len, (n - p) * dv_tab[s]);
            check("pwm2 edges", edges - e0, 2);
            check("pins c d", {output_pin_c, output_pin_d}, 2'h0);
            rd(`TPWM_OFS_MODE);
            check("pwm2 halted", d[0], 1'b0);
            rd(`TPWM_OFS_COUNT);
            check("pwm2 count", d, s[1] ? 0 : m);
        end
        run_clk <= 1'b0;
        $display("test pwm2 sources done");
        // only the chosen edge starts
        for (int e = 1; e < 4; e++) begin
            trig_lvl <= e == 1;
            cfg(12, 9, 3, 32'h0, 32'h20 | e << 6, 32'h7);
            e0 = edges;
            trig_lvl <= e == 2;
            repeat (30) @(posedge aclk);
            check("armed idle", edges - e0, 0);
            trig_lvl <= ~trig_lvl;
            repeat (40) @(posedge aclk);
            check("trig edges", edges - e0, 2);
            check("trig width", hi_len, 6);
            wr(`TPWM_OFS_MODE, 32'h0);
        end
        $display("test trigger done");
        print_verdict();
    end
endmodule : test_timer_pwm_and_pwm2_output
`default_nettype wire
